/* pkg/led_flash_pkg.sv */
// Function
// RULE1 - codes 0x00..0x7f give pulse length (code+1)*2 ms
// RULE2 - codes 0x80 and up give (code-127)*8+256 ms
// RULE3 - duration register resets to 0x23 (72 ms), read and write
// RULE4 - mode 00 is shutdown, or external torch when torch select is 10
// RULE5 - mode 01 drives indicator from 6 lsb, pwm at 31.25 khz by duty code
// RULE6 - mode 10 is assist light using 7 lsb of sink level
// RULE7 - mode 11 is flash using the full sink level code
// RULE8 - end of flash pulse clears sink enable and mode field
// RULE9 - sink enable resets to 0; sinks drive only while it is 1
// RULE10 - host writes zero to control bit 2 and ignores its read value
// RULE11 - host clears mode, enable and torch select before 5 v mode
// RULE12 - low supply at enable rise sets undervoltage flag, then reduce or stay off
// RULE13 - timer starts with flash pulse and ends it when duration elapses
package led_flash_pkg;
  localparam logic [7:0] duration_addr    = 8'h05;
  localparam logic [7:0] control_addr     = 8'h06;
  localparam logic [7:0] duration_reset   = 8'h23;
  localparam logic [7:0] control_reset    = 8'h00;
  localparam logic [7:0] segment_split    = 8'h80;
  localparam logic [7:0] segment_offset   = 8'h7f;
  localparam int         fine_step_ms     = 2;
  localparam int         coarse_step_ms   = 8;
  localparam int         coarse_base_ms   = 256;
  localparam int         clock_hz         = 20000000;
  localparam int         ms_cycles        = clock_hz / 1000;
  localparam int         pwm_hz_x100      = 3125000;
  localparam int         pwm_tick_cycles  = (clock_hz * 100 / pwm_hz_x100) / 16;
  localparam int         mode_lsb         = 0;
  localparam int         enable_bit       = 3;
  localparam logic [1:0] torch_ext_code   = 2'h2;

  typedef enum logic [1:0] {
    mode_off    = 2'b00,
    mode_ind    = 2'b01,
    mode_assist = 2'b10,
    mode_flash  = 2'b11
  } mode_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
  } reg_req_type;

  typedef struct packed {
    logic [7:0] level;
    logic       enable;
  } sink_drive_type;
endpackage

/* design/led_flash_mode_timer_control.sv */
`timescale 1ns/1ps
module led_flash_mode_timer_control #(
  parameter int ms_cycles_p = led_flash_pkg::ms_cycles
) (
  input  wire logic                         clock,
  input  wire logic                         rst,
  input  wire led_flash_pkg::reg_req_type   req,
  output logic [7:0]                        rdata,
  input  wire logic [7:0]                   sink_level,
  input  wire logic [3:0]                   ind_duty,
  input  wire logic [1:0]                   torch_select,
  input  wire logic                         vin_low,
  input  wire logic                         uv_shutdown_sel,
  output led_flash_pkg::sink_drive_type     current_sink_outputs,
  output logic                              ext_torch,
  output logic                              uv_flag,
  output logic                              reduce_current,
  output logic                              timeout_flag
);
  import led_flash_pkg::*;

  initial begin
    if (ms_cycles_p < 1) $error("ms_cycles_p must be at least 1");
  end

  logic [7:0]  duration;
  logic [7:0]  next_duration;
  logic [1:0]  mode;
  logic [1:0]  next_mode;
  logic        enable;
  logic        next_enable;
  logic [10:0] ms_left;
  logic [10:0] next_ms_left;
  logic [31:0] ms_div;
  logic [31:0] next_ms_div;
  logic        running;
  logic        next_running;
  logic        uv;
  logic        next_uv;
  logic        uv_hold;
  logic        next_uv_hold;
  logic        tout;
  logic        next_tout;
  logic [31:0] pwm_div;
  logic [31:0] next_pwm_div;
  logic [3:0]  pwm_phase;
  logic [3:0]  next_pwm_phase;
  logic [10:0] length_ms;
  logic        enable_rise;
  sink_drive_type next_drive;

  always_comb begin
    if (duration < segment_split) begin                                   // RULE1
      length_ms = 11'((32'(duration) + 32'd1) * 32'(fine_step_ms));
    end else begin                                                        // RULE2
      length_ms = 11'((32'(duration) - 32'(segment_offset)) * 32'(coarse_step_ms)
                      + 32'(coarse_base_ms));
    end
  end

  assign enable_rise = req.wr && req.addr == control_addr && req.wdata[enable_bit] && !enable;

  always_comb begin
    next_duration = duration;
    next_mode     = mode;
    next_enable   = enable;
    next_running  = running;
    next_ms_left  = ms_left;
    next_ms_div   = ms_div;
    next_uv       = uv;
    next_uv_hold  = uv_hold;
    next_tout     = tout;
    if (req.wr && req.addr == duration_addr) begin
      next_duration = req.wdata;                                          // RULE3
    end
    if (req.wr && req.addr == control_addr) begin
      next_mode   = req.wdata[mode_lsb +: 2];
      next_enable = req.wdata[enable_bit];   // bit 2 is dropped on write
      if (enable_rise) begin
        next_uv_hold = vin_low && uv_shutdown_sel;                        // RULE12
        if (vin_low) begin
          next_uv = 1'b1;                                                 // RULE12
        end
      end
      if (!req.wdata[enable_bit]) begin
        next_uv_hold = 1'b0;
      end
    end
    // pulse begins when enabled in flash mode and no timer runs
    if (!running && next_enable && next_mode == mode_flash) begin        // RULE13
      next_running = 1'b1;
      next_ms_left = length_ms;
      next_ms_div  = 32'(ms_cycles_p - 1);
    end else if (running) begin
      if (!next_enable || next_mode != mode_flash) begin
        next_running = 1'b0;  // host aborted the flash
      end else if (ms_div != 32'd0) begin
        next_ms_div = ms_div - 32'd1;
      end else if (ms_left <= 11'd1) begin                                // RULE13
        next_running = 1'b0;
        next_enable  = 1'b0;                                              // RULE8
        next_mode    = mode_off;                                          // RULE8
        next_tout    = 1'b1;
      end else begin
        next_ms_left = ms_left - 11'd1;
        next_ms_div  = 32'(ms_cycles_p - 1);
      end
    end
  end

  always_comb begin
    next_pwm_phase = pwm_phase;
    next_pwm_div   = pwm_div - 32'd1;
    if (pwm_div == 32'd0) begin
      next_pwm_div   = 32'(pwm_tick_cycles - 1);
      next_pwm_phase = pwm_phase + 4'd1;  // 16 steps make one 31.25 khz period
    end
  end

  always_comb begin
    next_drive = '0;
    if (enable && !uv_hold) begin                                         // RULE9
      case (mode_type'(mode))
        mode_ind: begin                                                   // RULE5
          next_drive.level  = {2'h0, sink_level[5:0]};
          next_drive.enable = pwm_phase < ind_duty;
        end
        mode_assist: begin                                                // RULE6
          next_drive.level  = {1'h0, sink_level[6:0]};
          next_drive.enable = 1'b1;
        end
        mode_flash: begin                                                 // RULE7
          next_drive.level  = sink_level;
          next_drive.enable = 1'b1;
        end
        default: begin                                                    // RULE4
          next_drive = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      duration             <= duration_reset;                             // RULE3
      mode                 <= control_reset[1:0];
      enable               <= 1'b0;                                       // RULE9
      running              <= 1'b0;
      ms_left              <= 11'h000;
      ms_div               <= 32'h0;
      uv                   <= 1'b0;
      uv_hold              <= 1'b0;
      tout                 <= 1'b0;
      pwm_div              <= 32'h0;
      pwm_phase            <= 4'h0;
      current_sink_outputs <= '0;
      ext_torch            <= 1'b0;
      rdata                <= 8'h00;
    end else begin
      duration             <= next_duration;
      mode                 <= next_mode;
      enable               <= next_enable;
      running              <= next_running;
      ms_left              <= next_ms_left;
      ms_div               <= next_ms_div;
      uv                   <= next_uv;
      uv_hold              <= next_uv_hold;
      tout                 <= next_tout;
      pwm_div              <= next_pwm_div;
      pwm_phase            <= next_pwm_phase;
      current_sink_outputs <= next_drive;
      ext_torch            <= mode == mode_off && torch_select == torch_ext_code;  // RULE4
      case (req.addr)
        duration_addr: rdata <= duration;
        control_addr:  rdata <= {4'h0, enable, 1'b0, mode};  // RULE10
        default:       rdata <= 8'h00;
      endcase
    end
  end

  assign uv_flag        = uv;
  assign reduce_current = uv && !uv_hold && enable;
  assign timeout_flag   = tout;
endmodule

/* testbench/led_flash_monitor.sv */
`timescale 1ns/1ps
module led_flash_monitor (
  input wire logic                        clock,
  input wire logic                        rst,
  input wire led_flash_pkg::reg_req_type  req,
  input wire logic [7:0]                  rdata,
  input wire logic [7:0]                  sink_level,
  input wire logic [1:0]                  torch_select,
  input wire logic                        vin_low,
  input wire led_flash_pkg::sink_drive_type current_sink_outputs,
  input wire logic                        ext_torch,
  input wire logic                        uv_flag,
  input wire logic                        timeout_flag
);
  import led_flash_pkg::*;
  logic [7:0] dur;
  wire        cw = req.wr && req.addr == control_addr;
  // shadow of the duration register, so reads are judged against writes
  always_ff @(posedge clock or posedge rst)
    if (rst) dur <= duration_reset;
    else if (req.wr && req.addr == duration_addr) dur <= req.wdata;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  property p_off; cw && !req.wdata[3] ##1 !cw |-> ##1 !current_sink_outputs.enable; endproperty
  a_off: assert property (p_off) else $error("sink on while disabled");
  property p_flash; cw && req.wdata[3:0] == 4'hb && !vin_low && !uv_flag |-> ##2
    current_sink_outputs.enable && current_sink_outputs.level == sink_level; endproperty
  a_flash: assert property (p_flash) else $error("flash drive wrong");
  property p_assist; cw && req.wdata[3:0] == 4'ha && !uv_flag |-> ##2
    current_sink_outputs.level == {1'b0, sink_level[6:0]}; endproperty
  a_assist: assert property (p_assist) else $error("assist level wrong");
  property p_ind; cw && req.wdata[1:0] == 2'b01 |-> ##2 current_sink_outputs.level[7:6] == 2'b00;
  endproperty
  a_ind: assert property (p_ind) else $error("indicator level wrong");
  property p_torch; cw && req.wdata[1:0] == 2'b00 && torch_select == torch_ext_code ##1
    torch_select == torch_ext_code && !cw |=> ext_torch; endproperty
  a_torch: assert property (p_torch) else $error("torch not on");
  property p_end; $rose(timeout_flag) |=> !current_sink_outputs.enable; endproperty
  a_end: assert property (p_end) else $error("sink on after pulse");
  property p_dur; !req.wr && req.addr == duration_addr ##1 req.addr == duration_addr |->
    rdata == dur; endproperty
  a_dur: assert property (p_dur) else $error("duration readback wrong");
  property p_uv; $rose(uv_flag) |-> $past(vin_low); endproperty
  a_uv: assert property (p_uv) else $error("uv flag without low supply");
endmodule
bind led_flash_mode_timer_control led_flash_monitor led_flash_monitor_inst (.*);

/* testbench/led_host_model.sv */
`timescale 1ns/1ps
module led_host_model (
  input wire logic               clock,
  input wire logic [7:0]         rdata,
  output led_flash_pkg::reg_req_type req
);
  import led_flash_pkg::*;
  initial req = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    #1;
    req = '{addr: a, wdata: (a == control_addr) ? (d & 8'hfb) : d, wr: 1'b1};
    @(posedge clock);
    #1;
    req.wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    #1;
    req.addr = a;
    repeat (2) @(posedge clock);
    #1;
    d = rdata;
  endtask
endmodule

/* testbench/led_flash_mode_timer_control_tb.sv */
`timescale 1ns/1ps
module led_flash_mode_timer_control_tb;
  import led_flash_pkg::*;
  logic           clock = 0, rst = 1, vin_low = 0, uv_shutdown_sel = 1;
  logic [7:0]     sink_level = 8'hff, rdata, d;
  logic [3:0]     ind_duty = 4'h8;
  logic [1:0]     torch_select = 2'h0;
  reg_req_type    req;
  sink_drive_type current_sink_outputs;
  logic           ext_torch, uv_flag, reduce_current, timeout_flag;
  int             mismatches = 0, checked = 0, cycles = 0, n;
  always #25 clock = ~clock;
  led_flash_mode_timer_control #(.ms_cycles_p(4)) led_flash_mode_timer_control_inst (
    .clock(clock), .rst(rst), .req(req), .rdata(rdata), .sink_level(sink_level),
    .ind_duty(ind_duty), .torch_select(torch_select), .vin_low(vin_low),
    .uv_shutdown_sel(uv_shutdown_sel), .current_sink_outputs(current_sink_outputs),
    .ext_torch(ext_torch), .uv_flag(uv_flag), .reduce_current(reduce_current),
    .timeout_flag(timeout_flag));
  led_host_model host (.clock(clock), .rdata(rdata), .req(req));
  task automatic stop_test;
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask
  function automatic int len_ms(input logic [7:0] c);
    return c < segment_split ? (c + 1) * fine_step_ms : (c - 127) * coarse_step_ms + coarse_base_ms;
  endfunction
  // counts enabled cycles of one flash pulse at 4 cycles per ms
  task automatic pulse(input logic [7:0] c);
    host.wr(duration_addr, c);
    host.rd(duration_addr, d);
    check(16'(d), 16'(c));
    host.wr(control_addr, 8'h0b);
    n = 0;
    repeat (1200) begin
      tick(1);
      n += current_sink_outputs.enable;
    end
    check(16'(n >= 4 * len_ms(c) && n <= 4 * len_ms(c) + 1), 16'h1);
    host.rd(control_addr, d);
    check(16'(d), 16'h0);
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 6000) begin
      mismatches++;
      stop_test();
    end
  end
  initial begin
    tick(5);
    rst = 0;
    host.rd(duration_addr, d);
    check(16'(d), 16'h23);
    host.rd(control_addr, d);
    check(16'(d), 16'h0);
    host.rd(8'h07, d);
    check(16'(d), 16'h0);
    pulse(8'h00);
    check(16'(timeout_flag), 16'h1);
    pulse(8'h81);
    host.wr(control_addr, 8'h0a);
    tick(2);
    check(16'(current_sink_outputs.level), 16'h7f);
    host.wr(control_addr, 8'h09);
    tick(2);
    n = 0;
    repeat (640) begin
      tick(1);
      n += current_sink_outputs.enable;
    end
    check(16'(n), 16'd320);
    torch_select = 2'h2;
    host.wr(control_addr, 8'h00);
    tick(2);
    check(16'(ext_torch), 16'h1);
    check(16'(current_sink_outputs.enable), 16'h0);
    vin_low = 1;
    host.wr(control_addr, 8'h0b);
    tick(3);
    check(16'(uv_flag), 16'h1);
    check(16'(current_sink_outputs.enable), 16'h0);
    check(16'(reduce_current), 16'h0);
    // shutdown select off: low supply at the enable rise reduces instead
    host.wr(control_addr, 8'h00);
    uv_shutdown_sel = 0;
    host.wr(control_addr, 8'h0a);
    tick(2);
    check(16'(reduce_current), 16'h1);
    check(16'(current_sink_outputs.enable), 16'h1);
    stop_test();
  end
endmodule
